/* core/ccb_ctrl_bank.sv */
// Purpose: Two 16-bit charger control registers on an SMBus slave
// Assumes: 20 MHz clk; SMBus clock and data are open-drain pins
// Notes:   Word access, low byte first
// Behaviour
// - Comparator debounce 2us, 12us, 2ms, 5s
// - Exit bit ends learn on low battery
// - Learn enable only with battery present
// - Control one bit 11 enables reverse power
// - Control one bit 10 enables audio filter
// - Frequency code zero keeps pin resistor setting
// - Turbo enabled with turbo request turns battery gate on
// - Monitor disable only without adapter
// - Bit 4 picks battery or adapter monitor
// - Bit 3 enables system power monitor
// - Switching disable stops converter, gate on
// - Low rail threshold code; 2.4V one-cell
// - Control two bits 15:14 trickle current
// - Reverse power enable debounce 1.3s or 150ms
// - Bit 12 enables two-level adapter limit
// - Adapter-ok debounce 1.3s or 150ms
// - Insertions use 150ms until adapter gate first falls
// - Hot alert debounce; low rail fixed
// - Hot alert minimum asserted width code
// - Adapter gate off in reverse power if set
`timescale 1ns/100ps
`default_nettype none
`include "ccb_map.svh"
module ccb_ctrl_bank #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a, // Arbitrary value
   parameter int N_CMP2 = `CCB_MS(`CCB_T_CMP2_MS),
   parameter int N_CMP3 = `CCB_S(`CCB_T_CMP3_S),
   parameter int N_LONG = `CCB_MS(`CCB_T_LONG_MS),
   parameter int N_SHRT = `CCB_MS(`CCB_T_SHORT_MS),
   parameter int N_HDB2 = `CCB_US(`CCB_T_HDB2_US),
   parameter int N_HDB3 = `CCB_MS(`CCB_T_HDB3_MS),
   parameter int N_HW0  = `CCB_MS(`CCB_T_HW0_MS),
   parameter int N_HW1  = `CCB_MS(`CCB_T_HW1_MS),
   parameter int N_HW2  = `CCB_MS(`CCB_T_HW2_MS),
   parameter int N_HW3  = `CCB_MS(`CCB_T_HW3_MS),
   parameter int N_HW4  = `CCB_MS(`CCB_T_HW4_MS),
   parameter int N_HW5  = `CCB_US(`CCB_T_HW5_US)
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_o,
   output logic                   sda_oe,
   input  wire ccb_pkg::ccb_pins_t pin_in,
   input  wire logic [10:0]       rail_level,
   output ccb_pkg::ccb_ctl_t      ctl_out
);
   localparam int CW = `CCB_CNT_W;
   localparam logic [CW-1:0] ONE = CW'(1);

   if (N_CMP3 >= 2**CW || N_LONG >= 2**CW || N_CMP2 < 1 || N_SHRT < 1) begin : g_bad_count
      $error("ccb_ctrl_bank: count parameter out of range");
   end

   ccb_pkg::ccb_top_st_t r;
   ccb_pkg::ccb_top_st_t n;
   ccb_pkg::ccb_pins_t   pin_s;
   logic [CW-1:0]        cmp_lim;
   logic [CW-1:0]        adapter_ok_output_lim;
   logic [CW-1:0]        otg_lim;
   logic [CW-1:0]        hot_lim;
   logic [10:0]          lr_thr;
   logic                 cmp_q;
   logic                 adapter_ok_output_q;
   logic                 otg_q;
   logic                 hac_q;
   logic                 hdc_q;
   logic                 lr_q;

   // Read word selected by command code
   function automatic logic [15:0] rd_word(input logic [7:0] c,
                                           input logic [15:0] a,
                                           input logic [15:0] b);
      if (c == `CCB_CTL1_OFS)
         rd_word = a;
      else if (c == `CCB_CTL2_OFS)
         rd_word = b;
      else
         rd_word = 16'h0000;
   endfunction : rd_word

   // Minimum asserted width of the hot alert
   function automatic logic [CW-1:0] hot_width(input logic [2:0] code);
      case (code)
         3'h0:    hot_width = CW'(N_HW0);
         3'h1:    hot_width = CW'(N_HW1);
         3'h2:    hot_width = CW'(N_HW2);
         3'h3:    hot_width = CW'(N_HW3);
         3'h4:    hot_width = CW'(N_HW4);
         3'h5:    hot_width = CW'(N_HW5);
         3'h6:    hot_width = CW'(`CCB_US(`CCB_T_HW6_US));
         default: hot_width = '0;
      endcase
   endfunction : hot_width

   ////////////////////////////////////////////////////////////////////
   // Debounce limits from register fields
   assign pin_s = r.s2[7:0];
   always_comb begin
      case (r.ctl1[`CCB_C1_CMPDB_LSB +: 2])
         2'h0:    cmp_lim = CW'(`CCB_US(`CCB_T_CMP0_US));
         2'h1:    cmp_lim = CW'(`CCB_US(`CCB_T_CMP1_US));
         2'h2:    cmp_lim = CW'(N_CMP2);
         default: cmp_lim = CW'(N_CMP3);
      endcase
      case (r.ctl2[`CCB_C2_HOTDB_LSB +: 2])
         2'h0:    hot_lim = CW'(`CCB_US(`CCB_T_HDB0_US));
         2'h1:    hot_lim = CW'(`CCB_US(`CCB_T_HDB1_US));
         2'h2:    hot_lim = CW'(N_HDB2);
         default: hot_lim = CW'(N_HDB3);
      endcase
      // Short until the adapter gate first falls after reset, or when bit set
      if (!r.first_done || r.ctl2[`CCB_C2_ACIN_DB])
         adapter_ok_output_lim = CW'(N_SHRT);
      else
         adapter_ok_output_lim = CW'(N_LONG);
      otg_lim = r.ctl2[`CCB_C2_REV_DB] ? CW'(N_SHRT) : CW'(N_LONG);
      // Low rail threshold, 10 mV units
      if (pin_s.one_cell)
         lr_thr = `CCB_LR_ONECELL;
      else
         lr_thr = `CCB_LR_BASE + 11'(`CCB_LR_STEP * r.ctl1[`CCB_C1_LRAIL_LSB +: 2]);
   end

   ////////////////////////////////////////////////////////////////////
   // Debounce timers
   ccb_debounce u_cmp (.clk(clk), .rst_n(rst_n), .ce(ce), .lvl(pin_s.cmp_raw),
                       .limit(cmp_lim), .q(cmp_q));
   ccb_debounce u_adapter_ok_output (.clk(clk), .rst_n(rst_n), .ce(ce), .lvl(pin_s.adapter_in),
                        .limit(adapter_ok_output_lim), .q(adapter_ok_output_q));
   ccb_debounce u_otg (.clk(clk), .rst_n(rst_n), .ce(ce),
                       .lvl(r.ctl1[`CCB_C1_REV_EN]), .limit(otg_lim), .q(otg_q));
   ccb_debounce u_hac (.clk(clk), .rst_n(rst_n), .ce(ce), .lvl(pin_s.adapter_over),
                       .limit(hot_lim), .q(hac_q));
   ccb_debounce u_hdc (.clk(clk), .rst_n(rst_n), .ce(ce), .lvl(pin_s.discharge_over),
                       .limit(hot_lim), .q(hdc_q));
   ccb_debounce u_lr (.clk(clk), .rst_n(rst_n), .ce(ce), .lvl(rail_level < lr_thr),
                      .limit(CW'(`CCB_US(`CCB_T_LRDB_US))), .q(lr_q));

   ////////////////////////////////////////////////////////////////////
   // Next state: bus slave and control outputs
   always_comb begin
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
      logic [7:0] b;
      logic [15:0] word;
      logic       below;
      logic       src;
      n     = r;
      b     = {r.sh[6:0], r.s2[8]};
      word  = rd_word(r.cmd, r.ctl1, r.ctl2);
      below = 1'b0;
      src   = 1'b0;
      rise  = r.s2[9] & ~r.scl_p;
      fall  = ~r.s2[9] & r.scl_p;
      start = r.s2[9] & r.scl_p & r.sda_p & ~r.s2[8];
      stop  = r.s2[9] & r.scl_p & ~r.sda_p & r.s2[8];
      // Pin synchronisers
      n.s1    = {scl_in, sda_in, pin_in};
      n.s2    = r.s1;
      n.scl_p = r.s2[9];
      n.sda_p = r.s2[8];
      if (start) begin
         n.bst    = ccb_pkg::ST_RX;
         n.bitc   = 3'h0;
         n.idx    = 2'h0;
         n.done   = 1'b0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.bst    = ccb_pkg::ST_IDLE;
         n.sda_oe = 1'b0;
      end else begin
         case (r.bst)
            ccb_pkg::ST_RX: begin
               if (rise) begin
                  n.sh   = b;
                  n.bitc = r.bitc + 3'h1;
                  if (r.bitc == 3'h7) begin
                     n.bst = ccb_pkg::ST_ACKW;
                     case (r.idx)
                        2'h0: begin
                           n.ack = (b[7:1] == SLAVE_ADDR);
                           n.rw  = b[0];
                           n.hi  = 1'b0;
                        end
                        2'h1: begin
                           n.cmd = b;
                           n.ack = (b == `CCB_CTL1_OFS) || (b == `CCB_CTL2_OFS);
                        end
                        2'h2: begin
                           n.wlo = b;
                           n.ack = 1'b1;
                        end
                        default: begin
                           // Word completes on the high byte
                           n.ack  = !r.done;
                           n.done = 1'b1;
                           if (!r.done && r.cmd == `CCB_CTL1_OFS)
                              n.ctl1 = {b, r.wlo};
                           if (!r.done && r.cmd == `CCB_CTL2_OFS)
                              n.ctl2 = {b, r.wlo};
                        end
                     endcase
                  end
               end
            end
            ccb_pkg::ST_ACKW: begin
               if (fall) begin
                  n.sda_oe = r.ack;
                  n.bst    = r.ack ? ccb_pkg::ST_ACK : ccb_pkg::ST_IDLE;
               end
            end
            ccb_pkg::ST_ACK: begin
               if (fall) begin
                  n.bitc = 3'h0;
                  if (r.rw) begin
                     n.sh     = r.hi ? word[15:8] : word[7:0];
                     n.sda_oe = ~n.sh[7];
                     n.bst    = ccb_pkg::ST_TX;
                  end else begin
                     n.sda_oe = 1'b0;
                     n.idx    = (r.idx == 2'h3) ? 2'h3 : r.idx + 2'h1;
                     n.bst    = ccb_pkg::ST_RX;
                  end
               end
            end
            ccb_pkg::ST_TX: begin
               if (rise) begin
                  n.bitc = r.bitc + 3'h1;
                  if (r.bitc == 3'h7)
                     n.bst = ccb_pkg::ST_TXW;
               end else if (fall) begin
                  n.sh     = {r.sh[6:0], 1'b0};
                  n.sda_oe = ~r.sh[6];
               end
            end
            ccb_pkg::ST_TXW: begin
               if (fall) begin
                  n.sda_oe = 1'b0;
                  n.bst    = ccb_pkg::ST_RACK;
               end
            end
            ccb_pkg::ST_RACK: begin
               if (rise) begin
                  // Master ack after low byte sends high byte
                  if (!r.s2[8] && !r.hi) begin
                     n.hi  = 1'b1;
                     n.bst = ccb_pkg::ST_ACK;
                  end else begin
                     n.bst = ccb_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               n.bst    = ccb_pkg::ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
      n.sda_o = 1'b0;

      // Learn mode with sticky exit on low battery
      below = r.ctl1[`CCB_C1_LRN_EXIT] & pin_s.batt_below_min;
      if (!r.ctl1[`CCB_C1_LRN_EN])
         n.exited = 1'b0;
      else if (below)
         n.exited = 1'b1;
      n.out.learn_mode = r.ctl1[`CCB_C1_LRN_EN] & ~pin_s.battery_absent_pin
                         & ~below & ~r.exited;

      // Hot alert with minimum width
      src = hac_q | hdc_q | lr_q;
      if (src)
         n.hold = hot_width(r.ctl2[`CCB_C2_HOTW_LSB +: 3]);
      else if (r.hold != '0)
         n.hold = r.hold - ONE;
      n.out.processor_hot_alert = src | (n.hold != '0);
      n.out.low_rail_alert      = lr_q;

      // Straight configuration outputs
      n.out.comparator_out          = cmp_q;
      n.out.reverse_power_mode      = otg_q;
      n.out.audio_filter_en         = r.ctl1[`CCB_C1_AUDIO];
      n.out.freq_override           = r.ctl1[`CCB_C1_FREQ_LSB +: 2];
      n.out.freq_from_program_pin   = (r.ctl1[`CCB_C1_FREQ_LSB +: 2] == 2'h0);
      n.out.turbo_en                = ~r.ctl1[`CCB_C1_TURBO_DIS];
      n.out.switching_en            = ~r.ctl1[`CCB_C1_SW_DIS];
      n.out.monitors_en             = adapter_ok_output_q | ~r.ctl1[`CCB_C1_MON_DIS];
      n.out.monitor_sel_battery     = r.ctl1[`CCB_C1_MON_SEL];
      n.out.system_power_monitor_en = r.ctl1[`CCB_C1_SYSPWR];
      n.out.trickle_code            = r.ctl2[`CCB_C2_TRKL_LSB +: 2];
      n.out.two_level_limit_en      = r.ctl2[`CCB_C2_TWO_LVL];
      n.out.adapter_ok_output       = adapter_ok_output_q;
      // Battery gate: switching off, turbo, or battery only
      n.out.battery_switch_gate = r.ctl1[`CCB_C1_SW_DIS]
                                  | (~r.ctl1[`CCB_C1_TURBO_DIS] & pin_s.turbo_request)
                                  | ~adapter_ok_output_q;
      // Adapter gate; reverse power keeps it on unless bit set
      n.out.adapter_switch_gate = adapter_ok_output_q
                                  | (otg_q & ~r.ctl2[`CCB_C2_ASG_OTG]);
      n.first_done = r.first_done
                     | (r.out.adapter_switch_gate & ~n.out.adapter_switch_gate);
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r      <= '0;
         r.bst  <= ccb_pkg::ST_IDLE;
         r.ctl1 <= `CCB_CTL1_RST;
         r.ctl2 <= `CCB_CTL2_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   assign sda_o   = r.sda_o;
   assign sda_oe  = r.sda_oe;
   assign ctl_out = r.out;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_learn_gate : assert property (@(posedge clk) disable iff (!rst_n)
      $rose(ctl_out.learn_mode) |-> $past(r.ctl1[`CCB_C1_LRN_EN])
                                    && !$past(pin_s.battery_absent_pin))
      else $error("learn mode entered without enable or battery");
   a_monitor_force : assert property (@(posedge clk) disable iff (!rst_n)
      $past(ce && adapter_ok_output_q) |-> ctl_out.monitors_en)
      else $error("monitors off with adapter present");
   a_switch_off : assert property (@(posedge clk) disable iff (!rst_n)
      $past(ce && r.ctl1[`CCB_C1_SW_DIS]) |-> !ctl_out.switching_en
                                             && ctl_out.battery_switch_gate)
      else $error("switching disable not applied");
   a_hot_hold : assert property (@(posedge clk) disable iff (!rst_n)
      ce && r.hold > ONE |=> ctl_out.processor_hot_alert)
      else $error("hot alert released before minimum width");
   a_otg_gate : assert property (@(posedge clk) disable iff (!rst_n)
      $past(ce && otg_q && !adapter_ok_output_q) |->
         ctl_out.adapter_switch_gate == !$past(r.ctl2[`CCB_C2_ASG_OTG]))
      else $error("adapter gate wrong in reverse power");
   a_word_write : assert property (@(posedge clk) disable iff (!rst_n)
      $changed(r.ctl1) |-> $past(r.bst == ccb_pkg::ST_RX && r.idx == 2'h3
                                 && r.cmd == `CCB_CTL1_OFS))
      else $error("control one changed outside a word write");
   a_first_plug : assert property (@(posedge clk) disable iff (!rst_n)
      $rose(adapter_ok_output_q) && !r.first_done |-> $past(u_adapter_ok_output.r.cnt) == CW'(N_SHRT))
      else $error("first insertion not using short debounce");
   a_freq_pass : assert property (@(posedge clk) disable iff (!rst_n)
      $past(ce && rst_n) |-> ctl_out.freq_from_program_pin
                    == ($past(r.ctl1[`CCB_C1_FREQ_LSB +: 2]) == 2'h0))
      else $error("program pin frequency flag wrong");
endmodule : ccb_ctrl_bank
`default_nettype wire

/* core/ccb_debounce.sv */
// Purpose: Assertion debounce: output rises after level held limit cycles
// Assumes: Level already in the clk domain
// Notes:   Falls at once when the level drops
`timescale 1ns/100ps
`default_nettype none
`include "ccb_map.svh"
module ccb_debounce (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic                  lvl,
   input  wire logic [`CCB_CNT_W-1:0] limit,
   output logic                       q
);
   ccb_pkg::ccb_db_st_t r;
   ccb_pkg::ccb_db_st_t n;

   ////////////////////////////////////////////////////////////////////
   // Count while high, clear on low
   always_comb begin
      n = r;
      if (!lvl) begin
         n.cnt = '0;
         n.q   = 1'b0;
      end else if (r.cnt >= limit) begin
         n.q = 1'b1;
      end else begin
         n.cnt = r.cnt + `CCB_CNT_W'(1);
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   assign q = r.q;

   a_deb_rise : assert property (@(posedge clk) disable iff (!rst_n)
      ce && lvl && !r.q && r.cnt >= limit |=> q)
      else $error("debounce did not assert at its limit");
   a_deb_cause : assert property (@(posedge clk) disable iff (!rst_n)
      $rose(q) |-> $past(lvl) && $past(r.cnt) >= $past(limit))
      else $error("debounce asserted early");
endmodule : ccb_debounce
`default_nettype wire

/* core/ccb_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz core clock
// Notes:   Included by the package and the design files
`ifndef CCB_MAP_SVH
`define CCB_MAP_SVH
`define CCB_CLK_KHZ        20000
`define CCB_CNT_W          27
`define CCB_CTL1_OFS       8'h3c
`define CCB_CTL2_OFS       8'h3d
`define CCB_CTL1_RST       16'h0000
`define CCB_CTL2_RST       16'h0000
// Control one fields
`define CCB_C1_CMPDB_LSB   14
`define CCB_C1_LRN_EXIT    13
`define CCB_C1_LRN_EN      12
`define CCB_C1_REV_EN      11
`define CCB_C1_AUDIO       10
`define CCB_C1_FREQ_LSB    8
`define CCB_C1_TURBO_DIS   6
`define CCB_C1_MON_DIS     5
`define CCB_C1_MON_SEL     4
`define CCB_C1_SYSPWR      3
`define CCB_C1_SW_DIS      2
`define CCB_C1_LRAIL_LSB   0
// Control two fields
`define CCB_C2_TRKL_LSB    14
`define CCB_C2_REV_DB      13
`define CCB_C2_TWO_LVL     12
`define CCB_C2_ACIN_DB     11
`define CCB_C2_HOTDB_LSB   9
`define CCB_C2_HOTW_LSB    6
`define CCB_C2_ASG_OTG     5
// Times in their own units
`define CCB_T_CMP0_US      2
`define CCB_T_CMP1_US      12
`define CCB_T_CMP2_MS      2
`define CCB_T_CMP3_S       5
`define CCB_T_LONG_MS      1300
`define CCB_T_SHORT_MS     150
`define CCB_T_HDB0_US      7
`define CCB_T_HDB1_US      100
`define CCB_T_HDB2_US      500
`define CCB_T_HDB3_MS      1
`define CCB_T_LRDB_US      10
`define CCB_T_HW0_MS       10
`define CCB_T_HW1_MS       20
`define CCB_T_HW2_MS       15
`define CCB_T_HW3_MS       5
`define CCB_T_HW4_MS       1
`define CCB_T_HW5_US       500
`define CCB_T_HW6_US       100
// Time to cycle counts
`define CCB_US(t)          ((t) * `CCB_CLK_KHZ / 1000)
`define CCB_MS(t)          ((t) * `CCB_CLK_KHZ)
`define CCB_S(t)           ((t) * `CCB_CLK_KHZ * 1000)
// Low rail thresholds in 10 mV units
`define CCB_LR_BASE        11'h258
`define CCB_LR_STEP        11'h01e
`define CCB_LR_ONECELL     11'h0f0
`endif

/* core/ccb_pkg.sv */
// Purpose: Types shared by the configuration bank
// Assumes: ccb_map.svh on the include path
// Notes:   One-hot bus states
`include "ccb_map.svh"
package ccb_pkg;
   // Raw pins from the power stage
   typedef struct packed {
      logic cmp_raw;
      logic battery_absent_pin;
      logic adapter_in;
      logic batt_below_min;
      logic one_cell;
      logic turbo_request;
      logic adapter_over;
      logic discharge_over;
   } ccb_pins_t;
   // Controls towards the power stage
   typedef struct packed {
      logic       comparator_out;
      logic       learn_mode;
      logic       reverse_power_mode;
      logic       audio_filter_en;
      logic [1:0] freq_override;
      logic       freq_from_program_pin;
      logic       turbo_en;
      logic       battery_switch_gate;
      logic       monitors_en;
      logic       monitor_sel_battery;
      logic       system_power_monitor_en;
      logic       switching_en;
      logic [1:0] trickle_code;
      logic       two_level_limit_en;
      logic       adapter_ok_output;
      logic       adapter_switch_gate;
      logic       processor_hot_alert;
      logic       low_rail_alert;
   } ccb_ctl_t;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RX   = 7'h02,
      ST_ACKW = 7'h04,
      ST_ACK  = 7'h08,
      ST_TX   = 7'h10,
      ST_TXW  = 7'h20,
      ST_RACK = 7'h40
   } ccb_bus_st_t;
   typedef struct packed {
      logic [9:0]            s1;
      logic [9:0]            s2;
      logic                  scl_p;
      logic                  sda_p;
      ccb_bus_st_t           bst;
      logic [2:0]            bitc;
      logic [1:0]            idx;
      logic                  rw;
      logic                  hi;
      logic                  ack;
      logic                  done;
      logic [7:0]            sh;
      logic [7:0]            cmd;
      logic [7:0]            wlo;
      logic [15:0]           ctl1;
      logic [15:0]           ctl2;
      logic                  sda_oe;
      logic                  sda_o;
      logic                  exited;
      logic                  first_done;
      logic [`CCB_CNT_W-1:0] hold;
      ccb_ctl_t              out;
   } ccb_top_st_t;
   typedef struct packed {
      logic [`CCB_CNT_W-1:0] cnt;
      logic                  q;
   } ccb_db_st_t;
endpackage : ccb_pkg

/* tb/ccb_ctrl_bank_tb_top.sv */
// Purpose: Self-checking bench for the charger control bank
// Assumes: Host model on the SMBus pins
// Notes:   Short debounce counts set by parameter
`timescale 1ns/100ps
`default_nettype none
module ccb_ctrl_bank_tb_top;
   logic               clk, rst_n, scl, sda_line, sda_o, sda_oe, nk;
   logic [15:0]        rd;
   logic [10:0]        rl;
   ccb_pkg::ccb_pins_t pins;
   ccb_pkg::ccb_ctl_t  ctl;
   int                 n_mismatch = 0, samples_checked = 0, c;
   ccb_ctrl_bank #(.N_LONG(200), .N_SHRT(100), .N_HW0(50)) ccb_ctrl_bank_i (.clk(clk),
      .rst_n(rst_n), .ce(1'b1), .scl_in(scl), .sda_in(sda_line), .sda_o(sda_o),
      .sda_oe(sda_oe), .pin_in(pins), .rail_level(rl), .ctl_out(ctl));
   ccb_host_model #(.ADDR(7'h2a)) ccb_host_model_i (.clk(clk), .sda_oe(sda_oe), .scl(scl),
      .sda_line(sda_line));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      ccb_host_model_i.wr_word(a, d, nk);
   endtask : wr
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      pins = '0;
      rl = 11'h3e8;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      ccb_host_model_i.rd_word(8'h3c, rd, nk);
      chk(rd, 16'h0000);
      ccb_host_model_i.rd_word(8'h3d, rd, nk);
      chk(rd, 16'h0000);
      chk({11'h0, ctl.turbo_en, ctl.switching_en, ctl.monitors_en, ctl.freq_from_program_pin,
           sda_o}, 16'h001e);
      $display("test reset done");
      // Every frequency and trickle code with the plain enables
      for (int k = 0; k < 4; k++) begin
         wr(8'h3c, {5'h0, 1'b1, k[1:0], 8'h3c});
         wr(8'h3d, {k[1:0], 2'b11, 12'h0});
         ccb_host_model_i.rd_word(8'h3c, rd, nk);
         chk(rd, {5'h0, 1'b1, k[1:0], 8'h3c});
         chk({7'h0, ctl.audio_filter_en, ctl.freq_override, ctl.freq_from_program_pin,
              ctl.monitors_en, ctl.monitor_sel_battery, ctl.system_power_monitor_en,
              ctl.switching_en, ctl.battery_switch_gate},
             {7'h0, 1'b1, k[1:0], k == 0, 5'b01101});
         chk({12'h0, ctl.trickle_code, ctl.two_level_limit_en, 1'b0},
             {12'h0, k[1:0], 2'b10});
      end
      $display("test codes done");
      ccb_host_model_i.wr_word(8'h3e, 16'h0000, nk);
      chk({15'h0, nk}, 16'h0001);
      // Reverse power with the short debounce selected
      wr(8'h3c, 16'h0800);
      c = 0;
      while (!ctl.reverse_power_mode && c < 300) begin
         @(posedge clk);
         c++;
      end
      chk({15'h0, c > 40 && c < 130}, 16'h0001);
      chk({15'h0, ctl.adapter_switch_gate}, 16'h0001);
      wr(8'h3d, 16'h3020);
      chk({15'h0, ctl.adapter_switch_gate}, 16'h0000);
      $display("test reverse done");
      // Learn needs the battery present; exit bit ends it on low battery
      pins.battery_absent_pin <= 1'b1;
      wr(8'h3c, 16'h3020);
      chk({14'h0, ctl.learn_mode, ctl.monitors_en}, 16'h0000);
      pins.battery_absent_pin <= 1'b0;
      repeat (8) @(posedge clk);
      chk({15'h0, ctl.learn_mode}, 16'h0001);
      pins.batt_below_min <= 1'b1;
      repeat (4) @(posedge clk);
      pins.batt_below_min <= 1'b0;
      repeat (4) @(posedge clk);
      chk({15'h0, ctl.learn_mode}, 16'h0000);
      $display("test learn done");
      // Adapter after a gate fall uses the long debounce, forces monitors on
      pins.adapter_in <= 1'b1;
      pins.cmp_raw    <= 1'b1;
      c = 0;
      while (!ctl.adapter_ok_output && c < 400) begin
         @(posedge clk);
         c++;
      end
      chk({15'h0, c > 150 && c < 260}, 16'h0001);
      chk({13'h0, ctl.monitors_en, ctl.comparator_out, ctl.battery_switch_gate},
          16'h0006);
      // Low rail alert, then the one-cell threshold clears it
      rl <= 11'h100;
      repeat (220) @(posedge clk);
      chk({14'h0, ctl.low_rail_alert, ctl.processor_hot_alert}, 16'h0003);
      pins.one_cell <= 1'b1;
      repeat (20) @(posedge clk);
      chk({14'h0, ctl.low_rail_alert, ctl.processor_hot_alert}, 16'h0001);
      repeat (60) @(posedge clk);
      chk({15'h0, ctl.processor_hot_alert}, 16'h0000);
      $display("test adapter and alert done");
      wrap_up();
   end
endmodule : ccb_ctrl_bank_tb_top
`default_nettype wire

/* tb/ccb_host_model.sv */
// Purpose: SMBus host model for the charger control bank
// Assumes: Data wire has a pull-up; device pulls low via sda_oe
// Notes:   Ten clk per clock phase, word access only
`timescale 1ns/100ps
`default_nettype none
module ccb_host_model #(
   parameter logic [6:0] ADDR = 7'h2a // Arbitrary value
) (
   input  wire logic clk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda_line
);
   logic sda_drv;
   // Wired-and of both open drains, pull-up when released
   assign sda_line = sda_drv & ~sda_oe;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic half;
      repeat (10) @(posedge clk);
   endtask : half
   // Start or repeated start
   task automatic start;
      sda_drv <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b0;
      half();
      scl <= 1'b0;
   endtask : start
   task automatic stop;
      sda_drv <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b1;
      half();
   endtask : stop
   // One bit, sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      half();
      scl <= 1'b1;
      half();
      r = sda_line;
      scl <= 1'b0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic nak);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(mack, nak);
   endtask : xfer
   // Word write, low byte first
   task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic nk);
      logic [7:0] rx;
      logic [3:0] n;
      start();
      xfer({ADDR, 1'b0}, 1'b1, rx, n[0]);
      xfer(cmd, 1'b1, rx, n[1]);
      xfer(d[7:0], 1'b1, rx, n[2]);
      xfer(d[15:8], 1'b1, rx, n[3]);
      stop();
      nk = |n;
   endtask : wr_word
   // Word read, host nacks the high byte
   task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic nk);
      logic [7:0] rx;
      logic [3:0] n;
      start();
      xfer({ADDR, 1'b0}, 1'b1, rx, n[0]);
      xfer(cmd, 1'b1, rx, n[1]);
      start();
      xfer({ADDR, 1'b1}, 1'b1, rx, n[2]);
      xfer(8'hff, 1'b0, d[7:0], n[3]);
      xfer(8'hff, 1'b1, d[15:8], n[3]);
      stop();
      nk = |n[2:0];
   endtask : rd_word
endmodule : ccb_host_model
`default_nettype wire
